// [src/aof_pkg.sv]
// package for the conversion output frame formatter: register map, fields, types
package aof_pkg;
  localparam int                 RES_W          = 12;
  localparam int                 FRAME_W        = 32;
  localparam int                 LEN_W          = 6;
  localparam logic [7:0]         OFS_OUT_CTL    = 8'h10;
  localparam logic [7:0]         OFS_RANGE      = 8'h14;
  localparam logic [7:0]         OFS_FLAGS      = 8'h18;
  localparam logic [31:0]        OUT_CTL_MASK   = 32'h0000_7D0F;
  localparam logic [31:0]        RANGE_MASK     = 32'h0000_004F;
  localparam logic [31:0]        OUT_CTL_RESET  = 32'h0000_0000;
  localparam logic [31:0]        RANGE_RESET    = 32'h0000_0000;
  localparam int                 B_DEV_ID       = 14;
  localparam int                 B_SUPPLY_LO    = 12;
  localparam int                 B_INPUT_LO     = 10;
  localparam int                 B_SPAN         = 8;
  localparam int                 B_PARITY       = 3;
  localparam int                 B_VREF_OFF     = 6;
  localparam logic [RES_W-1:0]   PAT_ALT1       = 12'h555;
  localparam logic [RES_W-1:0]   PAT_ALT2       = 12'h333;
  localparam logic [3:0]         DEV_ID_DEFAULT = 4'h5; // arbitrary value

  typedef enum logic [2:0] {
    AOF_PAT_ZERO = 3'b100,
    AOF_PAT_ONES = 3'b101,
    AOF_PAT_ALT1 = 3'b110,
    AOF_PAT_ALT2 = 3'b111
  } aof_pat_type;

  // active alarm flags coming from the threshold logic
  typedef struct packed {
    logic supply_hi;
    logic supply_lo;
    logic input_hi;
    logic input_lo;
  } aof_flags_type;

  // one built frame: msb-aligned bits and count of valid bits
  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [LEN_W-1:0]   len;
  } aof_frame_type;
endpackage

// [src/aof_formatter.sv]
// frame formatter with wishbone register slave
`timescale 1ns/100ps
module aof_formatter
  import aof_pkg::*;
#(
  parameter logic [3:0] DEV_ID = DEV_ID_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              conv_valid,
  input  wire logic [RES_W-1:0]  conv_result,
  input  wire aof_flags_type     alarm_flags,
  output aof_frame_type          frame,
  output logic                   frame_valid,
  output logic [3:0]             range_sel,
  output logic                   onchip_vref_off
);
  logic [31:0]      out_ctl;
  logic [31:0]      range_reg;
  logic             req;
  // write strobes for the two writable registers, before byte-lane gating
  logic             ctl_wr;
  logic             rng_wr;
  logic [31:0]      next_rd;
  aof_frame_type    next_frame;
  logic [RES_W-1:0] result_word;

  // a request is taken once; the ack cycle itself is not a new request
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctl_wr = req && wb_we_i && (wb_adr_i == OFS_OUT_CTL);
  assign rng_wr = req && wb_we_i && (wb_adr_i == OFS_RANGE);

  // one-cycle ack, dropped the cycle after
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // output control lane 0: parity enable and pattern select
  aof_lane_reg #(
    .MASK      (OUT_CTL_MASK[7:0]),
    .RESET_VAL (OUT_CTL_RESET[7:0])
  ) ctl_lane0_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (ctl_wr && wb_sel_i[0]),
    .wr_data (wb_dat_i[7:0]),
    .q       (out_ctl[7:0])
  );

  // output control lane 1: append enables and flag selects
  aof_lane_reg #(
    .MASK      (OUT_CTL_MASK[15:8]),
    .RESET_VAL (OUT_CTL_RESET[15:8])
  ) ctl_lane1_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (ctl_wr && wb_sel_i[1]),
    .wr_data (wb_dat_i[15:8]),
    .q       (out_ctl[15:8])
  );

  // output control lane 2: reserved, always reads zero
  aof_lane_reg #(
    .MASK      (OUT_CTL_MASK[23:16]),
    .RESET_VAL (OUT_CTL_RESET[23:16])
  ) ctl_lane2_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (ctl_wr && wb_sel_i[2]),
    .wr_data (wb_dat_i[23:16]),
    .q       (out_ctl[23:16])
  );

  // output control lane 3: reserved, always reads zero
  aof_lane_reg #(
    .MASK      (OUT_CTL_MASK[31:24]),
    .RESET_VAL (OUT_CTL_RESET[31:24])
  ) ctl_lane3_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (ctl_wr && wb_sel_i[3]),
    .wr_data (wb_dat_i[31:24]),
    .q       (out_ctl[31:24])
  );

  // range lane 0: range code and reference off; all codes stored as written
  aof_lane_reg #(
    .MASK      (RANGE_MASK[7:0]),
    .RESET_VAL (RANGE_RESET[7:0])
  ) rng_lane0_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (rng_wr && wb_sel_i[0]),
    .wr_data (wb_dat_i[7:0]),
    .q       (range_reg[7:0])
  );

  // range lane 1: reserved
  aof_lane_reg #(
    .MASK      (RANGE_MASK[15:8]),
    .RESET_VAL (RANGE_RESET[15:8])
  ) rng_lane1_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (rng_wr && wb_sel_i[1]),
    .wr_data (wb_dat_i[15:8]),
    .q       (range_reg[15:8])
  );

  // range lane 2: reserved
  aof_lane_reg #(
    .MASK      (RANGE_MASK[23:16]),
    .RESET_VAL (RANGE_RESET[23:16])
  ) rng_lane2_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (rng_wr && wb_sel_i[2]),
    .wr_data (wb_dat_i[23:16]),
    .q       (range_reg[23:16])
  );

  // range lane 3: reserved
  aof_lane_reg #(
    .MASK      (RANGE_MASK[31:24]),
    .RESET_VAL (RANGE_RESET[31:24])
  ) rng_lane3_i (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (rng_wr && wb_sel_i[3]),
    .wr_data (wb_dat_i[31:24]),
    .q       (range_reg[31:24])
  );

  assign range_sel       = range_reg[3:0];
  assign onchip_vref_off = range_reg[B_VREF_OFF];

  // read mux; unmapped addresses read zero and still ack
  always_comb begin
    if (wb_adr_i == OFS_OUT_CTL) begin
      next_rd = out_ctl;
    end else if (wb_adr_i == OFS_RANGE) begin
      next_rd = range_reg;
    end else if (wb_adr_i == OFS_FLAGS) begin
      next_rd = {26'h0, frame_valid, alarm_flags, 1'b0};
    end else begin
      next_rd = 32'h0000_0000;
    end
  end

  // read data register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rd;
    end
  end

  // result word: conversion data or a test pattern
  always_comb begin
    if (!out_ctl[2]) begin
      result_word = conv_result;
    end else begin
      case (aof_pat_type'(out_ctl[2:0]))
        AOF_PAT_ZERO: result_word = '0;
        AOF_PAT_ONES: result_word = '1;
        AOF_PAT_ALT1: result_word = PAT_ALT1;
        default:      result_word = PAT_ALT2;
      endcase
    end
  end

  // frame assembly, appending enabled fields in fixed order
  always_comb begin
    logic [FRAME_W-1:0] acc;
    logic [LEN_W-1:0]   n;
    logic               p_res;
    logic               p_all;
    acc   = '0;
    n     = LEN_W'(RES_W);
    acc   = FRAME_W'(result_word);
    p_res = ^result_word;
    p_all = p_res;
    // device id nibble comes first after the result
    if (out_ctl[B_DEV_ID]) begin
      acc   = {acc[FRAME_W-5:0], DEV_ID};
      n     = n + LEN_W'(4);
      p_all = p_all ^ (^DEV_ID);
    end
    // supply flags: high flag before low flag
    if (out_ctl[B_SUPPLY_LO]) begin
      acc   = {acc[FRAME_W-2:0], alarm_flags.supply_hi};
      n     = n + LEN_W'(1);
      p_all = p_all ^ alarm_flags.supply_hi;
    end
    if (out_ctl[B_SUPPLY_LO+1]) begin
      acc   = {acc[FRAME_W-2:0], alarm_flags.supply_lo};
      n     = n + LEN_W'(1);
      p_all = p_all ^ alarm_flags.supply_lo;
    end
    // input flags: high flag before low flag
    if (out_ctl[B_INPUT_LO]) begin
      acc   = {acc[FRAME_W-2:0], alarm_flags.input_hi};
      n     = n + LEN_W'(1);
      p_all = p_all ^ alarm_flags.input_hi;
    end
    if (out_ctl[B_INPUT_LO+1]) begin
      acc   = {acc[FRAME_W-2:0], alarm_flags.input_lo};
      n     = n + LEN_W'(1);
      p_all = p_all ^ alarm_flags.input_lo;
    end
    // range code nibble, as stored in the range register
    if (out_ctl[B_SPAN]) begin
      acc   = {acc[FRAME_W-5:0], range_reg[3:0]};
      n     = n + LEN_W'(4);
      p_all = p_all ^ (^range_reg[3:0]);
    end
    // parity pair last; frame parity covers the result and every appended field
    if (out_ctl[B_PARITY]) begin
      acc = {acc[FRAME_W-3:0], p_res, p_all};
      n   = n + LEN_W'(2);
    end
    next_frame.bits = acc << (LEN_W'(FRAME_W) - n); // msb-align first bit out
    next_frame.len  = n;
  end

  // frame captured on each conversion strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame       <= '0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= conv_valid;
      if (conv_valid) begin
        frame <= next_frame;
      end
    end
  end
endmodule

// one byte lane of a control register
// reserved bits are masked on every write, so they can never read back
// as one, whatever software puts on the bus
module aof_lane_reg
  import aof_pkg::*;
#(
  parameter logic [7:0] MASK      = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  // write on the taken edge, masked bits held at zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= RESET_VAL & MASK;
    end else if (wr_en) begin
      q <= wr_data & MASK;
    end
  end
endmodule

// [tb/aof_formatter_sva.sv]
// concurrent checks on the formatter ports
`timescale 1ns/100ps
module aof_formatter_chk
  import aof_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          conv_valid,
  input wire aof_frame_type frame,
  input wire logic          frame_valid,
  input wire logic [3:0]    range_sel,
  input wire logic          onchip_vref_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // bus answer timing, then frame timing and register contents
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_frame_next: assert property (conv_valid |=> frame_valid)
    else $error("frame late");
  chk_frame_cause: assert property (frame_valid |-> $past(conv_valid))
    else $error("frame uncaused");
  chk_frame_len: assert property (frame_valid |-> frame.len inside {[6'h0C:6'h1A]})
    else $error("frame length");
  chk_ctl_rsv: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_OUT_CTL
    |-> (wb_dat_o & ~OUT_CTL_MASK) == 32'h0) else $error("ctl reserved");
  chk_rng_rsv: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_RANGE
    |-> (wb_dat_o & ~RANGE_MASK) == 32'h0) else $error("range reserved");
  chk_rng_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_RANGE
    && wb_sel_i[0] |-> range_sel == wb_dat_i[3:0] && onchip_vref_off == wb_dat_i[6])
    else $error("range write");
endmodule
bind aof_formatter aof_formatter_chk aof_formatter_chk_i (.clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .conv_valid, .frame, .frame_valid, .range_sel, .onchip_vref_off);

// [tb/aof_host_model.sv]
// host side model that captures each built frame
`timescale 1ns/100ps
module aof_host_model
  import aof_pkg::*;
(
  input wire logic          clk,
  input wire aof_frame_type frame,
  input wire logic          frame_valid,
  output aof_frame_type     got,
  output int                n_got
);
  // one frame per valid pulse, length set by the enabled fields
  always_ff @(posedge clk) begin
    if (frame_valid) begin
      got <= frame;
      n_got <= n_got + 1;
    end
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the frame formatter
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top
  import aof_pkg::*;
();
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, cv = 0, ack, fv, vref, p;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, rsel, r;
  logic [31:0] dat = 0, q, dat_o, eb;
  logic [11:0] res = 0;
  logic [15:0] c;
  aof_flags_type flg = 0;
  aof_frame_type frame, got;
  int n_got, en, n_fail = 0, checked = 0, cycles = 0;
  always #10 clk = ~clk;
  aof_formatter aof_formatter_i (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .conv_valid(cv), .conv_result(res), .alarm_flags(flg), .frame, .frame_valid(fv),
    .range_sel(rsel), .onchip_vref_off(vref));
  aof_host_model aof_host_model_i (.clk, .frame, .frame_valid(fv), .got, .n_got);
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // append w bits of v to the expected frame, msb first
  task automatic add(input logic [11:0] v, input int w);
    for (int i = w - 1; i >= 0; i--) begin
      eb[31 - en] = v[i];
      en++;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    wb(0, OFS_OUT_CTL, 0, 4'hF); `CHK("ctl", 32'h0, q)
    wb(0, OFS_RANGE, 0, 4'hF); `CHK("rng", 32'h0, q)
    wb(1, OFS_OUT_CTL, '1, 4'h2); wb(0, OFS_OUT_CTL, 0, 4'hF); `CHK("ctl", 32'h7D00, q)
    wb(1, OFS_RANGE, '1, 4'hF); wb(0, OFS_RANGE, 0, 4'hF); `CHK("rng", 32'h4F, q)
    wb(1, 8'h1C, '1, 4'hF); wb(0, 8'h1C, 0, 4'hF); `CHK("unmapped", 32'h0, q)
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      c = {1'b0, i[0], i[1:0], i[2:1], 1'b0, i[3], 4'h0, i[0] | i[3], i[2:0]};
      r = {i[0], 1'b0, i[2:1]};
      wb(1, OFS_OUT_CTL, {16'h0, c}, 4'hF);
      wb(1, OFS_RANGE, {25'h0, i[1], 2'b00, r}, 4'hF);
      `CHK("range_sel", r, rsel)
      `CHK("vref_off", i[1], vref)
      @(posedge clk);
      {cv, res, flg} <= {1'b1, 12'hA5C ^ 12'(i * 37), 4'(i) ^ 4'h9};
      @(posedge clk);
      cv <= 0;
      @(posedge clk);
      #1;
      eb = 0;
      en = 0;
      add(c[2] ? (c[1] ? (c[0] ? PAT_ALT2 : PAT_ALT1) : {12{c[0]}}) : res, 12);
      if (c[14]) add(DEV_ID_DEFAULT, 4);
      if (c[12]) add(flg.supply_hi, 1);
      if (c[13]) add(flg.supply_lo, 1);
      if (c[10]) add(flg.input_hi, 1);
      if (c[11]) add(flg.input_lo, 1);
      if (c[8]) add(r, 4);
      p = ^eb;
      if (c[3]) begin
        add(^eb[31:20], 1);
        add(p, 1);
      end
      `CHK("bits", eb, got.bits)
      `CHK("len", 6'(en), got.len)
    end
    `CHK("frames", 16, n_got)
    wb(0, OFS_FLAGS, 0, 4'hF); `CHK("flags", {26'h0, 1'b0, flg, 1'b0}, q)
    $display("frame test done");
    report_and_stop();
  end
endmodule
